// ==== common/fcsu_map.svh ====
// Register offsets, field positions, flash command codes and timing counts
// for the flash command/status host controller.
// Assumes a 100 MHz mclk; included by bare name wherever needed.
`ifndef FCSU_MAP_SVH
`define FCSU_MAP_SVH

// Software register offsets
`define FCSU_REG_CTRL      8'h00
`define FCSU_REG_ADDR      8'h04
`define FCSU_REG_DATA      8'h08
`define FCSU_REG_STATUS    8'h0c
`define FCSU_REG_RDATA     8'h10

// Control register fields
`define FCSU_CTRL_OP_LSB   0
`define FCSU_CTRL_OP_MSB   3
`define FCSU_CTRL_SUPPLY   8
`define FCSU_CTRL_DEVRST   9
`define FCSU_CTRL_RESET    32'h0000_0000

// Status register fields
`define FCSU_ST_BUSY       0
`define FCSU_ST_REFUSED    1
`define FCSU_ST_RBPIN      2
`define FCSU_ST_FL_LSB     8
`define FCSU_ST_FL_MSB     15
`define FCSU_FLASH_SR_RST  8'h80
`define FCSU_SR_READY      7

// Flash command codes
`define FCSU_CMD_READ_ARRAY  16'h00ff
`define FCSU_CMD_READ_STATUS 16'h0070
`define FCSU_CMD_READ_ID     16'h0090
`define FCSU_CMD_QUERY       16'h0098
`define FCSU_CMD_CLEAR       16'h0050
`define FCSU_CMD_PROGRAM     16'h0040
`define FCSU_CMD_PROGRAM_ALT 16'h0010
`define FCSU_CMD_BUF_PROGRAM 16'h00e8
`define FCSU_CMD_ERASE       16'h0020
`define FCSU_CMD_CONFIRM     16'h00d0
`define FCSU_CMD_SUSPEND     16'h00b0
`define FCSU_CMD_RESUME      16'h00d0
`define FCSU_CMD_LOCK_SETUP  16'h0060
`define FCSU_CMD_LOCK        16'h0001
`define FCSU_CMD_PAGE_CFG    16'h0004
`define FCSU_CMD_RB_CFG      16'h00b8
`define FCSU_CMD_OTP         16'h00c0

// Timing: times in ns, counts in mclk cycles
`define FCSU_MCLK_MHZ      100
`define FCSU_T_WPULSE_NS   70
`define FCSU_T_ACCESS_NS   100
`define FCSU_SYNC_STAGES   2
`define FCSU_WPULSE_CYC    ((`FCSU_T_WPULSE_NS * `FCSU_MCLK_MHZ + 999) / 1000)
`define FCSU_RPULSE_CYC    ((`FCSU_T_ACCESS_NS * `FCSU_MCLK_MHZ + 999) / 1000 + `FCSU_SYNC_STAGES)

`endif

// ==== common/fcsu_pkg.sv ====
// Types shared by the flash command/status host controller files.
// Constants live in fcsu_map.svh; this package holds types only.
package fcsu_pkg;

    typedef logic [23:0] fcsu_addr_t;
    typedef logic [15:0] fcsu_word_t;

    // Operations that software starts through the control register
    typedef enum logic [3:0] {
        FCSU_OP_NONE,
        FCSU_OP_READ_ARRAY,
        FCSU_OP_READ_STATUS,
        FCSU_OP_READ_ID,
        FCSU_OP_QUERY,
        FCSU_OP_CLEAR,
        FCSU_OP_PROGRAM,
        FCSU_OP_ERASE,
        FCSU_OP_SUSPEND,
        FCSU_OP_RESUME,
        FCSU_OP_LOCK,
        FCSU_OP_UNLOCK,
        FCSU_OP_PAGE_CFG,
        FCSU_OP_RB_CFG,
        FCSU_OP_OTP,
        FCSU_OP_READ_WORD
    } fcsu_op_t;

    typedef enum {FCSU_C_IDLE, FCSU_C_SETUP, FCSU_C_PULSE, FCSU_C_HOLD} fcsu_cphase_t;

    typedef enum {FCSU_S_IDLE, FCSU_S_W1, FCSU_S_W2, FCSU_S_POLL, FCSU_S_READ} fcsu_state_t;

    // Bus cycles that make up one operation
    typedef struct packed {
        logic       valid;
        logic       modify;
        fcsu_word_t code1;
        logic       addr_from_data;
        logic       two;
        fcsu_word_t code2;
        logic       code2_from_data;
        logic       poll;
        logic       read_only;
    } fcsu_plan_t;

endpackage

// ==== src/fcsu_cycle.sv ====
// One asynchronous bus cycle (write or read) on the flash pins.
// Assumes the caller holds start for one cycle only while idle.
`timescale 1ns/10ps
`include "fcsu_map.svh"
module fcsu_cycle (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                start,
    input  wire logic                is_write,
    input  wire fcsu_pkg::fcsu_addr_t addr,
    input  wire fcsu_pkg::fcsu_word_t wdata,
    input  wire fcsu_pkg::fcsu_word_t dq_in,
    output logic                     done,
    output fcsu_pkg::fcsu_word_t     rdata,
    output fcsu_pkg::fcsu_addr_t     flash_addr,
    output fcsu_pkg::fcsu_word_t     dq_out,
    output logic                     dq_oe,
    output logic                     chip_select_n,
    output logic                     we_n,
    output logic                     oe_n
);
    import fcsu_pkg::*;

    typedef struct packed {
        fcsu_cphase_t phase;
        logic [4:0]   cnt;
        logic         wr;
        logic         ce_n;
        logic         we_n;
        logic         oe_n;
        logic         dq_oe;
        fcsu_word_t   dq_out;
        fcsu_addr_t   a;
        fcsu_word_t   s1;
        fcsu_word_t   s2;
        fcsu_word_t   rdata;
        logic         done;
    } fcsu_cyc_t;

    fcsu_cyc_t r;
    fcsu_cyc_t next_r;

    // Each cycle ends with both strobes high, so every read starts a fresh latch
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        next_r.s1   = dq_in;
        next_r.s2   = r.s1;
        case (r.phase)
            FCSU_C_IDLE: begin
                if (start) begin
                    next_r.phase  = FCSU_C_SETUP;
                    next_r.wr     = is_write;
                    next_r.a      = addr;
                    next_r.dq_out = wdata;
                    next_r.dq_oe  = is_write;
                    next_r.ce_n   = 1'b0;
                end
            end
            FCSU_C_SETUP: begin
                next_r.phase = FCSU_C_PULSE;
                next_r.we_n  = ~r.wr;
                next_r.oe_n  = r.wr;
                next_r.cnt   = r.wr ? 5'(`FCSU_WPULSE_CYC - 1) : 5'(`FCSU_RPULSE_CYC - 1);
            end
            FCSU_C_PULSE: begin
                if (r.cnt == 5'h00) begin
                    // Data seen through the synchroniser's second stage only
                    next_r.phase = FCSU_C_HOLD;
                    next_r.we_n  = 1'b1;
                    next_r.oe_n  = 1'b1;
                    if (!r.wr) begin
                        next_r.rdata = r.s2;
                    end
                end else begin
                    next_r.cnt = r.cnt - 5'h01;
                end
            end
            default: begin
                // Address and data held one cycle past the write strobe rise
                next_r.phase = FCSU_C_IDLE;
                next_r.ce_n  = 1'b1;
                next_r.dq_oe = 1'b0;
                next_r.done  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r       <= '0;
            r.phase <= FCSU_C_IDLE;
            r.ce_n  <= 1'b1;
            r.we_n  <= 1'b1;
            r.oe_n  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign done          = r.done;
    assign rdata         = r.rdata;
    assign flash_addr    = r.a;
    assign dq_out        = r.dq_out;
    assign dq_oe         = r.dq_oe;
    assign chip_select_n = r.ce_n;
    assign we_n          = r.we_n;
    assign oe_n          = r.oe_n;
endmodule

// ==== src/fcsu_host.sv ====
// Host controller that drives a parallel NOR flash command decoder and
// reads back its status byte. Software reaches it over a simple register port.
// Assumes flash data and ready/busy pins are asynchronous to mclk.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "fcsu_map.svh"
module fcsu_host (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    output fcsu_pkg::fcsu_addr_t     flash_addr,
    output fcsu_pkg::fcsu_word_t     dq_out,
    output logic                     dq_oe,
    input  wire fcsu_pkg::fcsu_word_t dq_in,
    output logic                     chip_select_n,
    output logic                     we_n,
    output logic                     oe_n,
    output logic                     rp_n,
    output logic                     program_enable_supply,
    input  wire logic                ready_busy_pin
);
    import fcsu_pkg::*;

    // Command sequence of each operation; decoder writes land at any address
    function automatic fcsu_plan_t plan_of(input fcsu_op_t op);
        fcsu_plan_t p;
        p       = '0;
        p.valid = 1'b1;
        case (op)
            FCSU_OP_READ_ARRAY: p.code1 = `FCSU_CMD_READ_ARRAY;
            FCSU_OP_READ_ID:    p.code1 = `FCSU_CMD_READ_ID;
            FCSU_OP_QUERY:      p.code1 = `FCSU_CMD_QUERY;
            FCSU_OP_CLEAR:      p.code1 = `FCSU_CMD_CLEAR;
            FCSU_OP_SUSPEND:    p.code1 = `FCSU_CMD_SUSPEND;
            FCSU_OP_RESUME:     p.code1 = `FCSU_CMD_RESUME;
            FCSU_OP_READ_STATUS: begin
                p.code1 = `FCSU_CMD_READ_STATUS;
                p.poll  = 1'b1;
            end
            FCSU_OP_PROGRAM: begin
                p.code1           = `FCSU_CMD_PROGRAM;
                p.two             = 1'b1;
                p.code2_from_data = 1'b1;
                p.poll            = 1'b1;
                p.modify          = 1'b1;
            end
            FCSU_OP_ERASE: begin
                p.code1  = `FCSU_CMD_ERASE;
                p.two    = 1'b1;
                p.code2  = `FCSU_CMD_CONFIRM;
                p.poll   = 1'b1;
                p.modify = 1'b1;
            end
            FCSU_OP_LOCK, FCSU_OP_UNLOCK: begin
                p.code1  = `FCSU_CMD_LOCK_SETUP;
                p.two    = 1'b1;
                p.code2  = (op == FCSU_OP_LOCK) ? `FCSU_CMD_LOCK : `FCSU_CMD_CONFIRM;
                p.poll   = 1'b1;
                p.modify = 1'b1;
            end
            FCSU_OP_PAGE_CFG: begin
                p.code1          = `FCSU_CMD_LOCK_SETUP;
                p.addr_from_data = 1'b1;
                p.two            = 1'b1;
                p.code2          = `FCSU_CMD_PAGE_CFG;
            end
            FCSU_OP_RB_CFG: begin
                p.code1           = `FCSU_CMD_RB_CFG;
                p.two             = 1'b1;
                p.code2_from_data = 1'b1;
            end
            FCSU_OP_OTP: begin
                p.code1           = `FCSU_CMD_OTP;
                p.two             = 1'b1;
                p.code2_from_data = 1'b1;
                p.poll            = 1'b1;
                p.modify          = 1'b1;
            end
            FCSU_OP_READ_WORD:  p.read_only = 1'b1;
            default:            p.valid = 1'b0;
        endcase
        return p;
    endfunction

    typedef struct packed {
        fcsu_state_t state;
        fcsu_plan_t  plan;
        logic        supply_en;
        logic        dev_reset;
        fcsu_addr_t  addr;
        fcsu_word_t  data;
        logic        busy;
        logic        refused;
        logic [7:0]  flash_sr;
        fcsu_word_t  read_word;
        logic        rb_s1;
        logic        rb_s2;
        logic        cyc_start;
        logic        cyc_write;
        fcsu_addr_t  cyc_addr;
        fcsu_word_t  cyc_wdata;
        logic [31:0] rd_data;
    } fcsu_host_t;

    fcsu_host_t r;
    fcsu_host_t next_r;

    logic       cyc_done;
    fcsu_word_t cyc_rdata;
    fcsu_plan_t req_plan;
    fcsu_op_t   req_op;
    logic       req_go;

    assign req_op   = fcsu_op_t'(reg_wdata[`FCSU_CTRL_OP_MSB:`FCSU_CTRL_OP_LSB]);
    assign req_plan = plan_of(req_op);
    assign req_go   = reg_wr && (reg_addr == `FCSU_REG_CTRL) && (req_op != FCSU_OP_NONE);

    // Register port, operation sequencer and pin synchroniser in one update
    always_comb begin
        next_r           = r;
        next_r.cyc_start = 1'b0;
        next_r.rb_s1     = ready_busy_pin;
        next_r.rb_s2     = r.rb_s1;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `FCSU_REG_CTRL) begin
                next_r.supply_en = reg_wdata[`FCSU_CTRL_SUPPLY];
                next_r.dev_reset = reg_wdata[`FCSU_CTRL_DEVRST];
            end else if (reg_addr == `FCSU_REG_ADDR && !r.busy) begin
                next_r.addr = reg_wdata[23:0];
            end else if (reg_addr == `FCSU_REG_DATA && !r.busy) begin
                next_r.data = reg_wdata[15:0];
            end
        end

        // Register reads, answered in the following cycle
        next_r.rd_data = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == `FCSU_REG_CTRL) begin
                next_r.rd_data[`FCSU_CTRL_SUPPLY] = r.supply_en;
                next_r.rd_data[`FCSU_CTRL_DEVRST] = r.dev_reset;
            end else if (reg_addr == `FCSU_REG_ADDR) begin
                next_r.rd_data[23:0] = r.addr;
            end else if (reg_addr == `FCSU_REG_DATA) begin
                next_r.rd_data[15:0] = r.data;
            end else if (reg_addr == `FCSU_REG_STATUS) begin
                next_r.rd_data[`FCSU_ST_BUSY]                    = r.busy;
                next_r.rd_data[`FCSU_ST_REFUSED]                 = r.refused;
                next_r.rd_data[`FCSU_ST_RBPIN]                   = r.rb_s2;
                next_r.rd_data[`FCSU_ST_FL_MSB:`FCSU_ST_FL_LSB]  = r.flash_sr;
            end else if (reg_addr == `FCSU_REG_RDATA) begin
                next_r.rd_data[15:0] = r.read_word;
            end
        end

        // A new operation is refused while busy, while the device is held in
        // reset, or when it would modify the array with the supply low
        if (req_go) begin
            if (r.busy || r.dev_reset || !req_plan.valid
                    || (req_plan.modify && !reg_wdata[`FCSU_CTRL_SUPPLY])) begin
                next_r.refused = 1'b1;
            end else begin
                next_r.refused   = 1'b0;
                next_r.busy      = 1'b1;
                next_r.plan      = req_plan;
                next_r.cyc_start = 1'b1;
                if (req_plan.read_only) begin
                    next_r.state     = FCSU_S_READ;
                    next_r.cyc_write = 1'b0;
                    next_r.cyc_addr  = r.addr;
                end else begin
                    next_r.state     = FCSU_S_W1;
                    next_r.cyc_write = 1'b1;
                    next_r.cyc_addr  = req_plan.addr_from_data ? {8'h00, r.data} : r.addr;
                    next_r.cyc_wdata = req_plan.code1;
                end
            end
        end

        case (r.state)
            FCSU_S_W1: begin
                if (cyc_done) begin
                    if (r.plan.two) begin
                        // Confirm follows the setup with nothing between
                        next_r.state     = FCSU_S_W2;
                        next_r.cyc_start = 1'b1;
                        next_r.cyc_wdata = r.plan.code2_from_data ? r.data : r.plan.code2;
                    end else if (r.plan.poll) begin
                        next_r.state     = FCSU_S_POLL;
                        next_r.cyc_start = 1'b1;
                        next_r.cyc_write = 1'b0;
                    end else begin
                        next_r.state = FCSU_S_IDLE;
                        next_r.busy  = 1'b0;
                    end
                end
            end
            FCSU_S_W2: begin
                if (cyc_done) begin
                    if (r.plan.poll) begin
                        next_r.state     = FCSU_S_POLL;
                        next_r.cyc_start = 1'b1;
                        next_r.cyc_write = 1'b0;
                    end else begin
                        next_r.state = FCSU_S_IDLE;
                        next_r.busy  = 1'b0;
                    end
                end
            end
            FCSU_S_POLL: begin
                // Only the low byte carries status; lower bits trusted once ready
                if (cyc_done) begin
                    next_r.flash_sr = cyc_rdata[7:0];
                    if (cyc_rdata[`FCSU_SR_READY]) begin
                        next_r.state = FCSU_S_IDLE;
                        next_r.busy  = 1'b0;
                    end else begin
                        // Each poll is a separate strobed read, so the latch refreshes
                        next_r.cyc_start = 1'b1;
                    end
                end
            end
            FCSU_S_READ: begin
                if (cyc_done) begin
                    next_r.read_word = cyc_rdata;
                    next_r.state     = FCSU_S_IDLE;
                    next_r.busy      = 1'b0;
                end
            end
            default: begin
            end
        endcase

        // Device reset leaves any running sequence alone; the status copy returns to 80h like the device
        if (r.dev_reset) begin
            next_r.flash_sr = `FCSU_FLASH_SR_RST;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r          <= '0;
            r.state    <= FCSU_S_IDLE;
            r.flash_sr <= `FCSU_FLASH_SR_RST;
        end else begin
            r <= next_r;
        end
    end

    // Bus cycle engine driving the flash pins
    fcsu_cycle u_cycle (
        .mclk          (mclk),
        .reset         (reset),
        .start         (r.cyc_start),
        .is_write      (r.cyc_write),
        .addr          (r.cyc_addr),
        .wdata         (r.cyc_wdata),
        .dq_in         (dq_in),
        .done          (cyc_done),
        .rdata         (cyc_rdata),
        .flash_addr    (flash_addr),
        .dq_out        (dq_out),
        .dq_oe         (dq_oe),
        .chip_select_n (chip_select_n),
        .we_n          (we_n),
        .oe_n          (oe_n)
    );

    assign reg_rdata             = r.rd_data;
    assign rp_n                  = ~r.dev_reset;
    assign program_enable_supply = r.supply_en;
endmodule

// ==== verification/fcsu_host_monitor.sv ====
// Assertion checker on the flash host controller ports.
// Assumes one clock domain; bound into fcsu_host at the foot of this file.
`timescale 1ns/10ps
module fcsu_host_chk (
    input wire logic                 mclk,
    input wire logic                 reset,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire fcsu_pkg::fcsu_addr_t flash_addr,
    input wire fcsu_pkg::fcsu_word_t dq_out,
    input wire logic                 dq_oe,
    input wire logic                 chip_select_n,
    input wire logic                 we_n,
    input wire logic                 oe_n,
    input wire logic                 program_enable_supply
);
    import fcsu_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Write strobe shape, framed by chip select
    a_we_width: assert property ($fell(we_n) |-> !we_n [*7] ##1 we_n) else $error("we width");
    a_cs_leads: assert property ($fell(we_n) |-> !$past(chip_select_n) && !chip_select_n) else $error("cs");
    a_cs_trails: assert property ($rose(we_n) |=> chip_select_n && !dq_oe) else $error("cs end");
    // Bus ownership: never both strobes, host drives only on writes
    a_no_clash: assert property (we_n || oe_n) else $error("we and oe");
    a_write_drv: assert property (!we_n |-> dq_oe) else $error("dq idle");
    a_read_free: assert property (!oe_n |-> !dq_oe) else $error("dq clash");
    // Each status read is one strobe of 12 cycles, then released
    a_read_len: assert property ($fell(oe_n) |-> !oe_n [*6] ##1 !oe_n [*6] ##1 oe_n) else $error("oe");
    a_addr_hold: assert property (!we_n && !$past(we_n) |-> $stable(flash_addr) && $stable(dq_out))
        else $error("addr moved");
    a_gate_mod: assert property ($fell(we_n) && dq_out inside {16'h0020, 16'h0040, 16'h00c0}
        |-> program_enable_supply) else $error("supply");
    a_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata");
    c_erase: cover property ($fell(we_n) && dq_out == 16'h0020);
    c_read: cover property ($fell(oe_n));
    c_lock: cover property ($fell(we_n) && dq_out == 16'h0001);
endmodule
bind fcsu_host fcsu_host_chk i_fcsu_host_chk (.mclk(mclk), .reset(reset), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .chip_select_n(chip_select_n), .we_n(we_n), .oe_n(oe_n), .program_enable_supply(program_enable_supply));

// ==== verification/fcsu_flash_model.sv ====
// Behavioural flash device: command decoder and status byte.
// Assumes the host holds chip select low around each strobe.
`timescale 1ns/10ps
module fcsu_flash_model #(
    parameter logic [15:0] ID_WORD  = 16'h5a3c, // Arbitrary value
    parameter logic [15:0] QRY_WORD = 16'h3c5a  // Arbitrary value
) (
    input wire fcsu_pkg::fcsu_addr_t flash_addr,
    input wire fcsu_pkg::fcsu_word_t dq_out,
    input wire logic                 chip_select_n,
    input wire logic                 we_n,
    input wire logic                 oe_n,
    input wire logic                 rp_n,
    input wire logic                 program_enable_supply,
    output fcsu_pkg::fcsu_word_t     dq_in,
    output logic                     ready_busy_pin
);
    import fcsu_pkg::*;
    logic [7:0]  sr = 8'h80; // Host never loads it
    logic [15:0] mode = 16'h00ff;
    logic [15:0] pend = 16'h0000;
    logic [15:0] p;
    logic [15:0] rd = 16'h0000;
    logic [15:0] page_cfg;
    logic [15:0] rb_cfg;
    logic        lk [0:127];
    // Reset returns the decoder to array reads and status to ready
    always @(negedge rp_n) begin
        sr = 8'h80;
        mode = 16'h00ff;
        pend = 16'h0000;
    end
    // Commands act on the strobe's rising edge and are never stored as data
    always @(posedge we_n) begin
        p = pend;
        pend = 16'h0000;
        if (!chip_select_n && rp_n && p != 16'h0000) begin // Confirm directly after setup
            mode = 16'h0070;
            if (p == 16'h0060 && dq_out == 16'h0004) page_cfg = flash_addr[15:0];
            else if (p == 16'h00b8) rb_cfg = dq_out;
            else if (p == 16'h0060 && dq_out inside {16'h0001, 16'h00d0})
                lk[flash_addr[23:17]] = (dq_out == 16'h0001);
            else if (p == 16'h0020 && dq_out != 16'h00d0) sr[5:4] = 2'b11;
            else if (!program_enable_supply) sr[4:3] = 2'b11; // Low supply refuses changes
            else if (lk[flash_addr[23:17]] === 1'b1) sr = sr | ((p == 16'h0020) ? 8'h22 : 8'h12);
            else begin // Erase, program, otp, buffer: busy for a while
                sr[7] = 1'b0;
                sr[7] <= #400 1'b1;
            end
        end else if (!chip_select_n && rp_n) begin
            case (dq_out) // Single-write commands act at once
                16'h00ff, 16'h0070, 16'h0090, 16'h0098: mode = dq_out;
                16'h0050: sr = sr & 8'hc5; // Errors stay until cleared
                16'h00b0: sr[2] = 1'b1;
                16'h00d0: sr[2] = 1'b0;
                16'h0020, 16'h0040, 16'h0010, 16'h0060, 16'h00b8, 16'h00c0, 16'h00e8: pend = dq_out;
                default: sr[5:4] = 2'b11;
            endcase
        end
    end
    // One word latched per strobe; busy returns 55h in the low bits
    always @(negedge oe_n) begin
        if (!chip_select_n)
            rd = (mode == 16'h0070) ? {8'h00, sr[7] ? sr : 8'h55} :
                 (mode == 16'h0090) ? ID_WORD : (mode == 16'h0098) ? QRY_WORD : 16'hffff;
    end
    // Released bus shows a flipped word, not a held one
    assign dq_in = (!chip_select_n && !oe_n) ? rd : ~rd;
    assign ready_busy_pin = sr[7];
endmodule

// ==== verification/fcsu_host_tb_top.sv ====
// Testbench for the flash host controller against a behavioural flash.
// Assumes fcsu_flash_model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`include "fcsu_map.svh"
module fcsu_host_tb_top;
    import fcsu_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] v;
    fcsu_addr_t  flash_addr;
    fcsu_word_t  dq_out;
    fcsu_word_t  dq_in;
    logic        dq_oe, chip_select_n, we_n, oe_n, rp_n, supply, rb_pin;
    int          fail_count = 0;
    int          n_compared = 0;
    // 100 MHz clock
    always #5 mclk = ~mclk;
    fcsu_host i_fcsu_host (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .chip_select_n(chip_select_n), .we_n(we_n), .oe_n(oe_n),
        .rp_n(rp_n), .program_enable_supply(supply), .ready_busy_pin(rb_pin));
    fcsu_flash_model i_fcsu_flash_model (.flash_addr(flash_addr), .dq_out(dq_out),
        .chip_select_n(chip_select_n), .we_n(we_n), .oe_n(oe_n), .rp_n(rp_n),
        .program_enable_supply(supply), .dq_in(dq_in), .ready_busy_pin(rb_pin));
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // Register port: one-cycle strobes, an idle edge after each
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    // Start an operation and poll busy under a bound
    task automatic run_op(input logic [3:0] op, input logic sup);
        int i;
        wr(`FCSU_REG_CTRL, {22'h0, 1'b0, sup, 4'h0, op});
        for (i = 0; i < 1000; i++) begin
            rd(`FCSU_REG_STATUS, v);
            if (v[0] === 1'b0)
                break;
        end
        if (i == 1000) begin
            $display("wrong value at %0t: got %h expected %h", $time, v, 32'h0);
            fail_count++;
            final_report();
        end
    endtask
    task automatic fl(input logic [7:0] e);
        rd(`FCSU_REG_STATUS, v);
        chk({24'h0, v[15:8]}, {24'h0, e});
    endtask
    task automatic t_reset;
        rd(`FCSU_REG_STATUS, v);
        chk(v, 32'h0000_8004);
        rd(8'h20, v);
        chk(v, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_status_erase;
        run_op(4'h2, 1'b0);
        fl(8'h80);
        wr(`FCSU_REG_ADDR, 32'h0002_0000);
        run_op(4'h7, 1'b1);
        fl(8'h80);
        run_op(4'h7, 1'b0);
        rd(`FCSU_REG_STATUS, v);
        chk({31'h0, v[1]}, 32'h1);
        $display("status and erase test done");
    endtask
    task automatic t_lock;
        run_op(4'ha, 1'b1);
        wr(`FCSU_REG_DATA, 32'h1234);
        run_op(4'h6, 1'b1);
        fl(8'h92);
        run_op(4'h2, 1'b0);
        fl(8'h92);
        run_op(4'h5, 1'b0);
        run_op(4'h2, 1'b0);
        fl(8'h80);
        run_op(4'hb, 1'b1);
        run_op(4'h6, 1'b1);
        fl(8'h80);
        run_op(4'he, 1'b1);
        fl(8'h80);
        $display("lock test done");
    endtask
    task automatic t_suspend;
        run_op(4'h8, 1'b0);
        run_op(4'h2, 1'b0);
        fl(8'h84);
        run_op(4'h9, 1'b0);
        run_op(4'h2, 1'b0);
        fl(8'h80);
        $display("suspend test done");
    endtask
    task automatic t_modes;
        run_op(4'h3, 1'b0);
        run_op(4'hf, 1'b0);
        rd(`FCSU_REG_RDATA, v);
        chk(v, {16'h0, i_fcsu_flash_model.ID_WORD});
        run_op(4'h4, 1'b0);
        run_op(4'hf, 1'b0);
        rd(`FCSU_REG_RDATA, v);
        chk(v, {16'h0, i_fcsu_flash_model.QRY_WORD});
        run_op(4'h1, 1'b0);
        run_op(4'hf, 1'b0);
        rd(`FCSU_REG_RDATA, v);
        chk(v, 32'h0000_ffff);
        $display("read mode test done");
    endtask
    task automatic t_cfg;
        wr(`FCSU_REG_DATA, 32'h2000);
        run_op(4'hc, 1'b0);
        chk({16'h0, i_fcsu_flash_model.page_cfg}, 32'h2000);
        wr(`FCSU_REG_DATA, 32'h0001);
        run_op(4'hd, 1'b0);
        chk({16'h0, i_fcsu_flash_model.rb_cfg}, 32'h0001);
        $display("config test done");
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_status_erase();
        t_lock();
        t_suspend();
        t_modes();
        t_cfg();
        final_report();
    end
endmodule
